// [verilog/i2c_port_dev.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_port_dev
  import i2c_port_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // Strap
  input wire logic i_addr_sel,
  // Bus
  i2c_link_if.dev link,
  // Register bank side
  output logic o_wr_stb,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_wr_data,
  output logic o_rd_stb,
  input wire logic [7:0] i_rd_data,
  output logic o_busy
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_PTR = 3'b011,
    ST_WDATA = 3'b010,
    ST_RDATA = 3'b110,
    ST_SKIP = 3'b111
  } dev_state_e;

  function automatic logic [7:0] shift_in(input logic [7:0] cur, input logic bit_in);
    shift_in = {cur[6:0], bit_in};
  endfunction : shift_in

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage is read by the second only
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_d;
  logic sda_d;
  logic [6:0] my_addr;
  logic [1:0] sel_sync;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (i_clk_en) begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
    end
  end

  // Strap caught by clock after reset release
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sel_sync <= 2'h0;
      my_addr <= ADDR_SEL_LOW;
    end else if (i_clk_en) begin
      sel_sync <= {sel_sync[0], i_addr_sel};
      my_addr <= sel_sync[1] ? ADDR_SEL_HIGH : ADDR_SEL_LOW;
    end
  end

  wire logic scl_now = scl_sync[1];
  wire logic sda_now = sda_sync[1];
  wire logic scl_rise = scl_now & ~scl_d;
  wire logic scl_fall = ~scl_now & scl_d;
  wire logic start_cond = scl_now & scl_d & sda_d & ~sda_now;
  wire logic stop_cond = scl_now & scl_d & ~sda_d & sda_now;

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine
  dev_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic [7:0] ptr;
  logic master_nack;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      txreg <= 8'hff;
      ptr <= PTR_RESET;
      master_nack <= 1'b0;
      o_wr_stb <= 1'b0;
      o_wr_data <= 8'h00;
      o_rd_stb <= 1'b0;
      link.sda_oe_dev <= 1'b0;
      o_busy <= 1'b0;
    end else if (i_clk_en) begin
      o_wr_stb <= 1'b0;
      o_rd_stb <= 1'b0;
      if (stop_cond) begin
        state <= ST_IDLE;
        link.sda_oe_dev <= 1'b0;
        o_busy <= 1'b0;
      end else if (start_cond) begin
        state <= ST_ADDR;
        // Parked so the SCL fall closing START wraps to bit 0
        bit_cnt <= 4'hf;
        link.sda_oe_dev <= 1'b0;
        o_busy <= 1'b1;
      end else if (state != ST_IDLE) begin
        if (scl_rise) begin
          if (bit_cnt < ACK_SLOT) begin
            shreg <= shift_in(shreg, sda_now);
          end else begin
            master_nack <= sda_now;
          end
        end
        if (scl_fall) begin
          if (bit_cnt == ACK_SLOT) begin
            // End of ninth clock: release ack, pick next byte
            bit_cnt <= 4'h0;
            link.sda_oe_dev <= 1'b0;
            if (state == ST_RDATA) begin
              if (master_nack) begin
                state <= ST_SKIP;
              end else begin
                txreg <= i_rd_data;
                link.sda_oe_dev <= ~i_rd_data[7];
                ptr <= ptr + 8'h01;
                o_rd_stb <= 1'b1;
              end
            end
            if (state == ST_ADDR) begin
              state <= ST_SKIP;
            end
          end else begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'(BITS_PER_BYTE - 1)) begin
              link.sda_oe_dev <= 1'b0;
              unique case (state)
                ST_ADDR: begin
                  if (shreg[7:1] == my_addr) begin
                    link.sda_oe_dev <= 1'b1;
                    if (shreg[0]) begin
                      state <= ST_RDATA;
                    end else begin
                      state <= ST_PTR;
                    end
                  end else begin
                    state <= ST_SKIP;
                  end
                end
                ST_PTR: begin
                  ptr <= shreg;
                  link.sda_oe_dev <= 1'b1;
                  state <= ST_WDATA;
                end
                ST_WDATA: begin
                  o_wr_data <= shreg;
                  o_wr_stb <= 1'b1;
                  ptr <= ptr + 8'h01;
                  link.sda_oe_dev <= 1'b1;
                end
                ST_RDATA: begin
                  link.sda_oe_dev <= 1'b0;
                end
                default: begin
                  link.sda_oe_dev <= 1'b0;
                end
              endcase
            end else if (state == ST_RDATA) begin
              link.sda_oe_dev <= ~txreg[3'(6 - bit_cnt[2:0])];
            end
          end
        end
      end
    end
  end

  // Register address presented to the bank; read data is the byte at ptr
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_addr <= PTR_RESET;
    end else if (i_clk_en) begin
      o_reg_addr <= (state == ST_WDATA && o_wr_stb) ? ptr - 8'h01 : ptr;
    end
  end

endmodule : i2c_port_dev
`default_nettype wire

// [inc/i2c_port_pkg.sv]
package i2c_port_pkg;
  // 7-bit slave addresses selected by the strap pin
  localparam logic [6:0] ADDR_SEL_LOW = 7'h30;
  localparam logic [6:0] ADDR_SEL_HIGH = 7'h32;
  localparam int unsigned BITS_PER_BYTE = 8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [7:0] PTR_RESET = 8'h00;
  // Host timing: system clock period and bus clock period
  localparam int unsigned REF_CLK_NS = 8;
  localparam int unsigned FAST_MODE_PERIOD_NS = 2500;
  localparam int unsigned QUARTER_CYCLES = FAST_MODE_PERIOD_NS / (4 * REF_CLK_NS);
  localparam logic [7:0] QUARTER_COUNT = 8'(QUARTER_CYCLES);
endpackage : i2c_port_pkg

// [inc/i2c_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
  // Open-drain: each party only pulls low
  logic scl_oe_host;
  logic sda_oe_host;
  logic sda_oe_dev;
  wire logic scl = ~scl_oe_host;
  wire logic sda = ~(sda_oe_host | sda_oe_dev);
  modport dev (input scl, input sda, output sda_oe_dev);
  modport host (input scl, input sda, output scl_oe_host, output sda_oe_host);
endinterface : i2c_link_if
`default_nettype wire

// [verilog/i2c_port_host.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_port_host
  import i2c_port_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // Command: one byte per request
  input wire logic i_req,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_read,
  input wire logic i_last,
  input wire logic [7:0] i_wdata,
  output logic o_done,
  output logic o_ack,
  output logic [7:0] o_rdata,
  output logic o_busy,
  // Bus
  i2c_link_if.host link
);

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_START = 3'b001,
    HS_BIT = 3'b011,
    HS_STOP = 3'b010,
    HS_DONE = 3'b110
  } host_state_e;

  host_state_e state;
  logic [7:0] tick;
  logic [1:0] phase;
  logic [3:0] bit_cnt;
  logic [7:0] sh;
  logic rd;
  logic last;
  logic stop_after;
  logic [1:0] sda_sync;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sda_sync <= 2'h3;
    end else if (i_clk_en) begin
      sda_sync <= {sda_sync[0], link.sda};
    end
  end

  wire logic q_end = (tick == QUARTER_COUNT - 8'h01);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= HS_IDLE;
      tick <= 8'h00;
      phase <= 2'h0;
      bit_cnt <= 4'h0;
      sh <= 8'h00;
      rd <= 1'b0;
      last <= 1'b0;
      stop_after <= 1'b0;
      link.scl_oe_host <= 1'b0;
      link.sda_oe_host <= 1'b0;
      o_done <= 1'b0;
      o_ack <= 1'b0;
      o_rdata <= 8'h00;
      o_busy <= 1'b0;
    end else if (i_clk_en) begin
      o_done <= 1'b0;
      tick <= (state == HS_IDLE || q_end) ? 8'h00 : tick + 8'h01;
      unique case (state)
        HS_IDLE: begin
          if (i_req) begin
            o_busy <= 1'b1;
            sh <= i_wdata;
            rd <= i_read;
            last <= i_last;
            stop_after <= i_stop;
            bit_cnt <= 4'h0;
            phase <= 2'h0;
            state <= i_start ? HS_START : HS_BIT;
          end
        end
        HS_START: if (q_end) begin
          phase <= phase + 2'h1;
          unique case (phase)
            2'h0: begin
              link.sda_oe_host <= 1'b0;
            end
            2'h1: begin
              link.scl_oe_host <= 1'b0;
            end
            2'h2: begin
              link.sda_oe_host <= 1'b1;
            end
            2'h3: begin
              link.scl_oe_host <= 1'b1;
              state <= HS_BIT;
            end
          endcase
        end
        HS_BIT: if (q_end) begin
          phase <= phase + 2'h1;
          unique case (phase)
            2'h0: begin
              if (bit_cnt < ACK_SLOT) begin
                link.sda_oe_host <= rd ? 1'b0 : ~sh[7];
              end else begin
                link.sda_oe_host <= rd ? ~last : 1'b0;
              end
            end
            2'h1: begin
              link.scl_oe_host <= 1'b0;
            end
            2'h2: begin
              if (bit_cnt < ACK_SLOT) begin
                sh <= {sh[6:0], sda_sync[1]};
              end else begin
                o_ack <= ~sda_sync[1];
              end
            end
            2'h3: begin
              link.scl_oe_host <= 1'b1;
              if (bit_cnt == ACK_SLOT) begin
                o_rdata <= sh;
                state <= stop_after ? HS_STOP : HS_DONE;
                phase <= 2'h0;
              end
              bit_cnt <= bit_cnt + 4'h1;
            end
          endcase
        end
        HS_STOP: if (q_end) begin
          phase <= phase + 2'h1;
          unique case (phase)
            2'h0: begin
              link.sda_oe_host <= 1'b1;
            end
            2'h1: begin
              link.scl_oe_host <= 1'b0;
            end
            2'h2: begin
              link.sda_oe_host <= 1'b0;
            end
            2'h3: begin
              state <= HS_DONE;
            end
          endcase
        end
        HS_DONE: begin
          o_done <= 1'b1;
          o_busy <= 1'b0;
          state <= HS_IDLE;
        end
        default: begin
          state <= HS_IDLE;
        end
      endcase
    end
  end

endmodule : i2c_port_host
`default_nettype wire

// [verif/i2c_link_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_link_sva
  import i2c_port_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Strap
  input wire logic i_addr_sel,
  // Bus
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_oe_host,
  input wire logic sda_oe_host,
  input wire logic sda_oe_dev
);
  logic scl_q, sda_q, first, mine, rd, nack;
  logic [3:0] cnt;
  logic [7:0] sh;
  wire logic start_det = scl && scl_q && sda_q && !sda;
  wire logic stop_det = scl && scl_q && !sda_q && sda;
  wire logic scl_rise = scl && !scl_q;
  wire logic scl_fall = !scl && scl_q;
  wire logic match = sh[7:1] == (i_addr_sel ? ADDR_SEL_HIGH : ADDR_SEL_LOW);
  wire logic ack_hi = scl && cnt == ACK_SLOT;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // Start parks at f so the fall after START wraps to bit 0
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) cnt <= 4'hf;
    else if (start_det) cnt <= 4'hf;
    else if (scl_fall) cnt <= (cnt == ACK_SLOT) ? 4'h0 : cnt + 4'h1;
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) sh <= 8'h00;
    else if (scl_rise && cnt != ACK_SLOT) sh <= {sh[6:0], sda};
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      {first, mine, rd, nack} <= 4'h0;
    end else if (start_det) begin
      {first, mine, nack} <= 3'h4;
    end else if (stop_det) begin
      {first, mine} <= 2'h0;
    end else if (scl_fall && cnt == ACK_SLOT && first) begin
      first <= 1'b0;
      mine <= match;
      rd <= sh[0];
    end else if (scl_rise && cnt == ACK_SLOT && mine && rd && sda) begin
      nack <= 1'b1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  a_addr_phase_quiet: assert property (first && cnt < ACK_SLOT |-> !sda_oe_dev)
    else $error("device drove data during address byte");
  a_addr_ack_match: assert property (first && ack_hi && match |-> sda_oe_dev)
    else $error("own address not acknowledged");
  a_addr_ack_other: assert property (first && ack_hi && !match |-> !sda_oe_dev)
    else $error("foreign address acknowledged");
  a_other_slave_quiet: assert property (!first && !mine |-> !sda_oe_dev)
    else $error("device drove bus while not addressed");
  a_write_byte_ack: assert property (mine && !rd && ack_hi |-> sda_oe_dev)
    else $error("written byte not acknowledged");
  a_read_ack_release: assert property (mine && rd && ack_hi |-> !sda_oe_dev)
    else $error("device held SDA in master ack slot");
  a_nack_release: assert property (nack |-> !sda_oe_dev)
    else $error("SDA not released after master NACK");
  a_dev_stable_high: assert property (scl && $past(scl) |-> $stable(sda_oe_dev))
    else $error("device changed SDA while SCL high");
  a_host_release_ack: assert property ((first || !rd) && ack_hi |-> !sda_oe_host)
    else $error("host drove SDA in slave ack slot");
  a_stop_release: assert property (stop_det |-> ##1 (!sda_oe_dev && !scl_oe_host) [*4])
    else $error("bus not idle after STOP");
  c_write_ack: cover property (mine && !rd && ack_hi);
  c_read_nack: cover property (nack && stop_det);
  c_foreign: cover property (first && ack_hi && !match);
endmodule : i2c_link_sva
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_ref_clk, i_rst, i_addr_sel, i_req, i_start, i_stop, i_read, i_last;
  logic [7:0] i_wdata, i_rd_data, o_reg_addr, o_wr_data, o_rdata;
  logic o_wr_stb, o_rd_stb, d_busy, o_done, o_ack, h_busy;
  logic [7:0] mem [256];
  int error_cnt = 0;
  int total_checks = 0;
  int rd_stb_cnt = 0;
  i2c_link_if link ();
  i2c_port_dev u_i2c_port_dev (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_clk_en(1'b1),
    .i_addr_sel(i_addr_sel), .link(link), .o_wr_stb(o_wr_stb), .o_reg_addr(o_reg_addr),
    .o_wr_data(o_wr_data), .o_rd_stb(o_rd_stb), .i_rd_data(i_rd_data), .o_busy(d_busy));
  i2c_port_host u_i2c_port_host (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_clk_en(1'b1),
    .i_req(i_req), .i_start(i_start), .i_stop(i_stop), .i_read(i_read), .i_last(i_last),
    .i_wdata(i_wdata), .o_done(o_done), .o_ack(o_ack), .o_rdata(o_rdata), .o_busy(h_busy),
    .link(link));
  i2c_link_sva u_i2c_link_sva (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr_sel(i_addr_sel),
    .scl(link.scl), .sda(link.sda), .scl_oe_host(link.scl_oe_host),
    .sda_oe_host(link.sda_oe_host), .sda_oe_dev(link.sda_oe_dev));
  // Register bank stand-in: combinational read, write on strobe
  assign i_rd_data = mem[o_reg_addr];
  always @(posedge i_ref_clk) begin
    if (o_wr_stb === 1'b1) mem[o_reg_addr] <= o_wr_data;
  end
  // One strobe per byte the device takes for sending
  always @(posedge i_ref_clk) begin
    if (o_rd_stb === 1'b1) rd_stb_cnt++;
  end
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One byte per request; waits for done with a bound
  task automatic xfer(input logic s, input logic p, input logic r, input logic l, input logic [7:0] d);
    int n;
    @(negedge i_ref_clk);
    {i_req, i_start, i_stop, i_read, i_last} = {1'b1, s, p, r, l};
    i_wdata = d;
    @(negedge i_ref_clk);
    i_req = 1'b0;
    for (n = 0; n < 4000 && o_done !== 1'b1; n++) @(negedge i_ref_clk);
    if (n == 4000) chk("done", 8'h00, 8'h01);
  endtask : xfer
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  //////////////////////////////////////////////////////////////////////////////
  // Sixteen bytes of about 3200 cycles each, with margin
  initial begin
    #(80000 * 8);
    error_cnt++;
    end_of_test();
  end
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    {i_rst, i_addr_sel, i_req, i_start, i_stop, i_read, i_last} = 7'h40;
    i_wdata = 8'h00;
    repeat (2) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_rst = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    xfer(1, 0, 0, 0, 8'h60);
    chk("wr addr ack", {7'h0, o_ack}, 8'h01);
    xfer(0, 0, 0, 0, 8'h05);
    chk("ptr ack", {7'h0, o_ack}, 8'h01);
    xfer(0, 0, 0, 0, 8'ha5);
    chk("data ack", {7'h0, o_ack}, 8'h01);
    xfer(0, 1, 0, 0, 8'h3c);
    chk("data 5", mem[5], 8'ha5);
    chk("data 6", mem[6], 8'h3c);
    chk("ptr after write", o_reg_addr, 8'h07);
    xfer(1, 0, 0, 0, 8'h60);
    xfer(0, 0, 0, 0, 8'h05);
    xfer(1, 0, 0, 0, 8'h61);
    chk("rep start ack", {7'h0, o_ack}, 8'h01);
    xfer(0, 0, 1, 0, 8'h00);
    chk("read 5", o_rdata, 8'ha5);
    xfer(0, 1, 1, 1, 8'h00);
    chk("read 6", o_rdata, 8'h3c);
    xfer(1, 0, 0, 0, 8'h61);
    xfer(0, 1, 1, 1, 8'h00);
    chk("read cur ptr", o_rdata, 8'h5d);
    xfer(1, 1, 0, 0, 8'h64);
    chk("foreign ack", {7'h0, o_ack}, 8'h00);
    @(negedge i_ref_clk);
    i_addr_sel = 1'b1;
    xfer(1, 0, 0, 0, 8'h64);
    chk("strap addr ack", {7'h0, o_ack}, 8'h01);
    xfer(0, 0, 0, 0, 8'h10);
    xfer(0, 1, 0, 0, 8'hc3);
    chk("data 16", mem[16], 8'hc3);
    xfer(1, 1, 0, 0, 8'h60);
    chk("low addr on high strap", {7'h0, o_ack}, 8'h00);
    repeat (4) @(negedge i_ref_clk);
    chk("idle", {4'h0, h_busy, d_busy, link.scl, link.sda}, 8'h03);
    chk("read strobes", 8'(rd_stb_cnt), 8'h03);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
